// file: hdl/hufc_device.sv
// device end of the host link uart with its character fifo
`timescale 1ns/1ps
`default_nettype none

module hufc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_in_valid,
    output logic                            o_in_ready,
    input  wire logic [WIDTH-1:0]           i_in_data,
    output logic                            o_out_valid,
    input  wire logic                       i_out_ready,
    output logic [WIDTH-1:0]                o_out_data,
    output logic [$clog2(DEPTH+2)-1:0]      o_level
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned LW = $clog2(DEPTH + 2);

    typedef struct packed {
        logic [AW-1:0]    wr;
        logic [AW-1:0]    rd;
        logic [AW:0]      cnt;
        logic             in_ready;
        logic             out_valid;
        logic [WIDTH-1:0] out_data;
    } hufc_fifo_st_t;

    logic [WIDTH-1:0] mem [DEPTH];
    hufc_fifo_st_t    s;
    hufc_fifo_st_t    next_s;
    logic             push;
    logic             load;

    // output register refills when empty or taken
    always_comb begin
        push   = i_in_valid && s.in_ready;
        load   = (s.cnt != '0) && (!s.out_valid || i_out_ready);
        next_s = s;
        if (push) begin
            next_s.wr = s.wr + AW'(1);
        end
        if (load) begin
            next_s.out_data  = mem[s.rd];
            next_s.out_valid = 1'b1;
            next_s.rd        = s.rd + AW'(1);
        end else if (s.out_valid && i_out_ready) begin
            next_s.out_valid = 1'b0;
        end
        next_s.cnt      = s.cnt + (AW+1)'(push) - (AW+1)'(load);
        // the output register is a slot too, so depth is exact
        next_s.in_ready = (next_s.cnt + (AW+1)'(next_s.out_valid)) < (AW+1)'(DEPTH);
        if (i_rst) begin
            next_s          = '0;
            next_s.in_ready = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        s <= next_s;
    end

    // storage has no reset; the pointers guard it
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[s.wr] <= i_in_data;
        end
    end

    assign o_in_ready  = s.in_ready;
    assign o_out_valid = s.out_valid;
    assign o_out_data  = s.out_data;
    assign o_level     = LW'(s.cnt) + LW'(s.out_valid);
endmodule

module hufc_device #(
    parameter int unsigned P_READY_CYCLES = hufc_pkg::READY_CYC
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    hufc_link_if.device      link,
    input  wire logic [15:0] i_bit_cycles,
    input  wire logic        i_parity_en,
    input  wire logic        i_parity_odd,
    input  wire logic        i_tx_valid,
    output logic             o_tx_ready,
    input  wire logic [7:0]  i_tx_data,
    output logic             o_rx_valid,
    input  wire logic        i_rx_ready,
    output logic [7:0]       o_rx_data,
    output logic             o_frame_err,
    output logic             o_parity_err,
    output logic             o_rx_overrun,
    output logic             o_ready
);
    localparam int unsigned RLW = $clog2(hufc_pkg::RX_FIFO_DEPTH + 2);

    typedef struct packed {
        logic [21:0]        pwr;
        logic               ready;
        logic               rts;
        logic               cts1;
        logic               cts2;
        logic               rx1;
        logic               rx2;
        hufc_pkg::hufc_tx_t tx;
        hufc_pkg::hufc_rx_t rx;
        logic               ferr;
        logic               perr;
        logic               ovr;
    } hufc_dev_st_t;

    hufc_dev_st_t     s;
    hufc_dev_st_t     next_s;
    logic [15:0]      bc;
    logic             go;
    logic             txf_valid;
    logic [7:0]       txf_data;
    logic             rxf_ready;
    logic [RLW-1:0]   rxf_level;

    // user characters wait here for the link
    hufc_fifo #(
        .WIDTH (hufc_pkg::DATA_BITS),
        .DEPTH (hufc_pkg::TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (i_rst),
        .i_in_valid  (i_tx_valid),
        .o_in_ready  (o_tx_ready),
        .i_in_data   (i_tx_data),
        .o_out_valid (txf_valid),
        .i_out_ready (go),
        .o_out_data  (txf_data),
        .o_level     ()
    );

    // received chars; holds the threshold plus the host's slack
    hufc_fifo #(
        .WIDTH (hufc_pkg::DATA_BITS),
        .DEPTH (hufc_pkg::RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (i_rst),
        .i_in_valid  (s.rx.done),
        .o_in_ready  (rxf_ready),
        .i_in_data   (s.rx.data),
        .o_out_valid (o_rx_valid),
        .i_out_ready (i_rx_ready),
        .o_out_data  (o_rx_data),
        .o_level     (rxf_level)
    );

    // whole device state advances in one step
    always_comb begin
        bc     = hufc_pkg::bit_len(i_bit_cycles);
        next_s = s;
        // pins pass two flops
        next_s.cts1 = link.host_link_clear_to_send;
        next_s.cts2 = s.cts1;
        next_s.rx1  = link.host_link_receive;
        next_s.rx2  = s.rx1;
        // count to ready
        if (!s.ready) begin
            next_s.pwr = s.pwr + 22'h00_0001;
        end
        next_s.ready = s.ready || (s.pwr == 22'(P_READY_CYCLES));
        // new chars start only on low cts: one in flight may finish
        go = s.ready && txf_valid && !s.cts2 && (s.tx.ph == hufc_pkg::ph_idle);
        next_s.tx = hufc_pkg::tx_step(s.tx, go, txf_data, bc, i_parity_en,
                                      i_parity_odd);
        next_s.rx = hufc_pkg::rx_step(s.rx, s.rx2, bc, i_parity_en,
                                      i_parity_odd);
        // frame and parity flags pulse beside their character; overrun pulses one cycle later
        next_s.ferr = next_s.rx.done && next_s.rx.ferr;
        next_s.perr = next_s.rx.done && next_s.rx.perr;
        next_s.ovr  = s.rx.done && !rxf_ready;
        // throttle at a quarter full, leaving 24 slots of slack
        next_s.rts = !next_s.ready || (rxf_level >= RLW'(hufc_pkg::RX_THRESH));
        if (i_rst) begin
            next_s         = '0;
            next_s.rts     = hufc_pkg::RTS_RESET;
            next_s.cts1    = hufc_pkg::CTS_RESET;
            next_s.cts2    = hufc_pkg::CTS_RESET;
            next_s.rx1     = hufc_pkg::LINE_IDLE;
            next_s.rx2     = hufc_pkg::LINE_IDLE;
            next_s.tx.line = hufc_pkg::LINE_IDLE;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        s <= next_s;
    end

    // every output below is a state flop
    assign link.host_link_transmit        = s.tx.line;
    assign link.host_link_request_to_send = s.rts;
    assign o_frame_err                    = s.ferr;
    assign o_parity_err                   = s.perr;
    assign o_rx_overrun                   = s.ovr;
    assign o_ready                        = s.ready;
endmodule
`default_nettype wire

// file: hdl/hufc_host.sv
// host end of the host link uart
`timescale 1ns/1ps
`default_nettype none

module hufc_host (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    hufc_link_if.host        link,
    input  wire logic [15:0] i_bit_cycles,
    input  wire logic        i_parity_en,
    input  wire logic        i_parity_odd,
    input  wire logic        i_tx_valid,
    output logic             o_tx_ready,
    input  wire logic [7:0]  i_tx_data,
    input  wire logic        i_hold,
    output logic             o_rx_valid,
    output logic [7:0]       o_rx_data,
    output logic             o_frame_err,
    output logic             o_parity_err
);
    typedef struct packed {
        logic               cts;
        logic               rts1;
        logic               rts2;
        logic               rx1;
        logic               rx2;
        logic               tx_rdy;
        hufc_pkg::hufc_tx_t tx;
        hufc_pkg::hufc_rx_t rx;
    } hufc_host_st_t;

    hufc_host_st_t s;
    hufc_host_st_t next_s;
    logic [15:0]   bc;
    logic          go;

    // whole host state advances in one step
    always_comb begin
        bc     = hufc_pkg::bit_len(i_bit_cycles);
        next_s = s;
        next_s.rts1 = link.host_link_request_to_send;
        next_s.rts2 = s.rts1;
        next_s.rx1  = link.host_link_transmit;
        next_s.rx2  = s.rx1;
        // user level holds the device off
        next_s.cts = i_hold;
        // start only on low rts: a stop lands within one character
        go = i_tx_valid && s.tx_rdy;
        next_s.tx = hufc_pkg::tx_step(s.tx, go, i_tx_data, bc, i_parity_en,
                                      i_parity_odd);
        next_s.rx = hufc_pkg::rx_step(s.rx, s.rx2, bc, i_parity_en, i_parity_odd);
        next_s.tx_rdy = (next_s.tx.ph == hufc_pkg::ph_idle) && !next_s.rts2 && !go;
        if (i_rst) begin
            next_s         = '0;
            next_s.cts     = hufc_pkg::CTS_RESET;
            next_s.rts1    = hufc_pkg::RTS_RESET;
            next_s.rts2    = hufc_pkg::RTS_RESET;
            next_s.rx1     = hufc_pkg::LINE_IDLE;
            next_s.rx2     = hufc_pkg::LINE_IDLE;
            next_s.tx.line = hufc_pkg::LINE_IDLE;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        s <= next_s;
    end

    // received character is a one-cycle pulse with no back-pressure
    assign link.host_link_receive       = s.tx.line;
    assign link.host_link_clear_to_send = s.cts;
    assign o_tx_ready                   = s.tx_rdy;
    assign o_rx_valid                   = s.rx.done;
    assign o_rx_data                    = s.rx.data;
    assign o_frame_err                  = s.rx.done && s.rx.ferr;
    assign o_parity_err                 = s.rx.done && s.rx.perr;
endmodule
`default_nettype wire

// file: hdl/hufc_link_if.sv
// serial link lines between device and host
`timescale 1ns/1ps
`default_nettype none
interface hufc_link_if;
    logic host_link_transmit;
    logic host_link_receive;
    logic host_link_request_to_send;
    logic host_link_clear_to_send;

    // device end
    modport device (
        output host_link_transmit,
        output host_link_request_to_send,
        input  host_link_receive,
        input  host_link_clear_to_send
    );

    // host end
    modport host (
        input  host_link_transmit,
        input  host_link_request_to_send,
        output host_link_receive,
        output host_link_clear_to_send
    );
endinterface
`default_nettype wire

// file: hdl/hufc_pkg.sv
// constants, types and serial step functions of the host link
package hufc_pkg;
    // reference clock and supported bit rates
    localparam int unsigned CLK_HZ       = 32'h017D_7840;
    localparam int unsigned HZ_PER_MHZ   = 32'h000F_4240;
    localparam int unsigned BAUD_MIN_BPS = 32'h0000_927C;
    localparam int unsigned BAUD_MAX_BPS = 32'h003D_0900;
    // shortest bit rounds up, longest bit rounds down, in reference cycles
    localparam logic [15:0] BIT_CYC_MIN  = 16'((CLK_HZ + BAUD_MAX_BPS - 1) / BAUD_MAX_BPS);
    localparam logic [15:0] BIT_CYC_MAX  = 16'(CLK_HZ / BAUD_MIN_BPS);
    localparam int unsigned DATA_BITS    = 32'h0000_0008;
    // buffer depths and thresholds, in characters
    localparam int unsigned TX_FIFO_DEPTH = 32'h0000_0010;
    localparam int unsigned RX_FIFO_DEPTH = 32'h0000_0020;
    localparam int unsigned RX_THRESH     = RX_FIFO_DEPTH / 4;
    localparam int unsigned FLOW_SLACK    = 32'h0000_0010;
    // power-up: ready well inside the 100 ms limit
    localparam int unsigned READY_TIME_US = 32'h0000_03E8;
    localparam int unsigned READY_CYC     = READY_TIME_US * (CLK_HZ / HZ_PER_MHZ);
    // reset levels of the link lines
    localparam logic LINE_IDLE = 1'b1;
    localparam logic RTS_RESET = 1'b1;
    localparam logic CTS_RESET = 1'b1;

    typedef enum logic [2:0] {ph_idle, ph_start, ph_data, ph_par, ph_stop} hufc_phase_t;

    typedef struct packed {
        hufc_phase_t ph;
        logic [15:0] cnt;
        logic [2:0]  bit_ix;
        logic [7:0]  sh;
        logic        par;
        logic        line;
        logic        take;
    } hufc_tx_t;

    typedef struct packed {
        hufc_phase_t ph;
        logic [15:0] cnt;
        logic [2:0]  bit_ix;
        logic [7:0]  sh;
        logic        par;
        logic        done;
        logic [7:0]  data;
        logic        ferr;
        logic        perr;
    } hufc_rx_t;

    // clamp a bit length to the supported rates
    function automatic logic [15:0] bit_len(input logic [15:0] req);
        if (req < BIT_CYC_MIN) begin
            return BIT_CYC_MIN;
        end
        if (req > BIT_CYC_MAX) begin
            return BIT_CYC_MAX;
        end
        return req;
    endfunction

    // one cycle of the transmitter: start, data lsb first, parity, stop
    function automatic hufc_tx_t tx_step(input hufc_tx_t s, input logic go,
            input logic [7:0] d, input logic [15:0] bc, input logic pen, input logic podd);
        hufc_tx_t n;
        n      = s;
        n.take = 1'b0;
        if (s.ph != ph_idle) begin
            n.cnt = s.cnt - 16'h0001;
        end
        case (s.ph)
            ph_idle: begin
                n.line = LINE_IDLE;
                if (go) begin
                    n.ph   = ph_start;
                    n.line = 1'b0;
                    n.cnt  = bc - 16'h0001;
                    n.sh   = d;
                    n.par  = (^d) ^ podd;
                    n.take = 1'b1;
                end
            end
            ph_start: begin
                if (s.cnt == 16'h0000) begin
                    n.ph     = ph_data;
                    n.bit_ix = 3'h0;
                    n.line   = s.sh[0];
                    n.cnt    = bc - 16'h0001;
                end
            end
            ph_data: begin
                if (s.cnt == 16'h0000) begin
                    n.cnt = bc - 16'h0001;
                    if (s.bit_ix == 3'(DATA_BITS - 1)) begin
                        n.ph   = pen ? ph_par : ph_stop;
                        n.line = pen ? s.par : 1'b1;
                    end else begin
                        n.bit_ix = s.bit_ix + 3'h1;
                        n.sh     = {1'b0, s.sh[7:1]};
                        n.line   = s.sh[1];
                    end
                end
            end
            ph_par: begin
                if (s.cnt == 16'h0000) begin
                    n.ph   = ph_stop;
                    n.line = 1'b1;
                    n.cnt  = bc - 16'h0001;
                end
            end
            ph_stop: begin
                if (s.cnt == 16'h0000) begin
                    n.ph = ph_idle;
                end
            end
            default: begin
                n.ph   = ph_idle;
                n.line = LINE_IDLE;
            end
        endcase
        return n;
    endfunction

    // one receiver cycle: each bit sampled at its centre
    function automatic hufc_rx_t rx_step(input hufc_rx_t s, input logic line,
            input logic [15:0] bc, input logic pen, input logic podd);
        hufc_rx_t n;
        n      = s;
        n.done = 1'b0;
        if (s.ph != ph_idle) begin
            n.cnt = s.cnt - 16'h0001;
        end
        case (s.ph)
            ph_idle: begin
                if (!line) begin
                    n.ph  = ph_start;
                    n.cnt = {1'b0, bc[15:1]};
                end
            end
            ph_start: begin
                if (s.cnt == 16'h0000) begin
                    n.ph     = line ? ph_idle : ph_data;
                    n.cnt    = bc - 16'h0001;
                    n.bit_ix = 3'h0;
                end
            end
            ph_data: begin
                if (s.cnt == 16'h0000) begin
                    n.sh     = {line, s.sh[7:1]};
                    n.cnt    = bc - 16'h0001;
                    n.bit_ix = s.bit_ix + 3'h1;
                    if (s.bit_ix == 3'(DATA_BITS - 1)) begin
                        n.ph = pen ? ph_par : ph_stop;
                    end
                end
            end
            ph_par: begin
                if (s.cnt == 16'h0000) begin
                    n.par = line;
                    n.ph  = ph_stop;
                    n.cnt = bc - 16'h0001;
                end
            end
            ph_stop: begin
                if (s.cnt == 16'h0000) begin
                    n.ph   = ph_idle;
                    n.done = 1'b1;
                    n.data = s.sh;
                    n.ferr = !line;
                    n.perr = pen && (s.par != ((^s.sh) ^ podd));
                end
            end
            default: begin
                n.ph = ph_idle;
            end
        endcase
        return n;
    endfunction
endpackage

// file: test/hufc_assertions.sv
// concurrent checks on the link lines
`timescale 1ns/1ps
`default_nettype none
module hufc_assertions #(
    parameter int unsigned P_READY_CYCLES = 20
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic host_link_transmit,
    input  wire logic host_link_receive,
    input  wire logic host_link_request_to_send,
    input  wire logic host_link_clear_to_send
);
    // rts falls within this many edges of the power-up count
    localparam int READY_LIM = P_READY_CYCLES + 8;
    logic [7:0] cts_hi;
    logic [7:0] rts_hi;

    // cycles each flow line has stood high, saturating
    always_ff @(posedge i_ref_clk) begin
        cts_hi <= (i_rst || !host_link_clear_to_send) ? 8'h00 : cts_hi + 8'(cts_hi != 8'hFF);
        rts_hi <= (i_rst || !host_link_request_to_send) ? 8'h00 : rts_hi + 8'(rts_hi != 8'hFF);
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    // eight clocks a bit: every transmit and receive level lasts at least eight samples
    a_idle_after_reset:
    assert property ($fell(i_rst) |-> host_link_transmit && host_link_receive
        && host_link_request_to_send && host_link_clear_to_send)
        else $error("link not idle after reset");
    a_tx_low_len:
    assert property ($fell(host_link_transmit) |-> (!host_link_transmit)[*8])
        else $error("short low bit on transmit");
    a_tx_high_len:
    assert property ($rose(host_link_transmit) |-> host_link_transmit[*8])
        else $error("short high bit on transmit");
    a_rx_low_len:
    assert property ($fell(host_link_receive) |-> (!host_link_receive)[*8])
        else $error("short low bit on receive");
    a_rx_high_len:
    assert property ($rose(host_link_receive) |-> host_link_receive[*8])
        else $error("short high bit on receive");
    a_ready_rts_low:
    assert property ($fell(i_rst) |-> host_link_request_to_send[*8]
        ##[1:READY_LIM] !host_link_request_to_send)
        else $error("rts not lowered after power-up");
    a_cts_halts_tx:
    assert property (cts_hi > 8'h64 |-> !$fell(host_link_transmit))
        else $error("device started late after cts");
    a_rts_halts_host:
    assert property (rts_hi > 8'h64 |-> !$fell(host_link_receive))
        else $error("host started late after rts");
endmodule
`default_nettype wire

// file: test/tb.sv
// bench: device and host on one link, a second device on a rogue line
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int READY = 20;
    logic        i_ref_clk, i_rst, parity_en, parity_odd, h_hold;
    logic [15:0] bit_cycles;
    logic        d_tx_valid, d_tx_ready, d_rx_valid, d_rx_ready, d_ferr, d_perr, d_ovr, d_ready;
    logic [7:0]  d_tx_data, d_rx_data, h_tx_data, h_rx_data, b_rx_data;
    logic        h_tx_valid, h_tx_ready, h_rx_valid, h_ferr, h_perr, b_rx_valid, b_ferr, b_perr;
    logic        err_seen, b_ferr_seen, b_perr_seen;
    logic [7:0]  hq[$];
    logic [7:0]  dq[$];
    logic [7:0]  bq[$];
    int          failures, n_tests, cyc;

    hufc_link_if link ();
    hufc_link_if link_b ();
    hufc_device #(.P_READY_CYCLES(READY)) i_hufc_device (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .link(link.device), .i_bit_cycles(bit_cycles), .i_parity_en(parity_en),
        .i_parity_odd(parity_odd), .i_tx_valid(d_tx_valid), .o_tx_ready(d_tx_ready),
        .i_tx_data(d_tx_data), .o_rx_valid(d_rx_valid), .i_rx_ready(d_rx_ready),
        .o_rx_data(d_rx_data), .o_frame_err(d_ferr), .o_parity_err(d_perr),
        .o_rx_overrun(d_ovr), .o_ready(d_ready));
    // second device takes bad frames from the bench
    hufc_device #(.P_READY_CYCLES(READY)) i_hufc_device_2 (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .link(link_b.device), .i_bit_cycles(bit_cycles), .i_parity_en(parity_en),
        .i_parity_odd(parity_odd), .i_tx_valid(1'h0), .o_tx_ready(), .i_tx_data(8'h00),
        .o_rx_valid(b_rx_valid), .i_rx_ready(1'h1), .o_rx_data(b_rx_data),
        .o_frame_err(b_ferr), .o_parity_err(b_perr), .o_rx_overrun(), .o_ready());
    hufc_host i_hufc_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link.host),
        .i_bit_cycles(bit_cycles), .i_parity_en(parity_en), .i_parity_odd(parity_odd),
        .i_tx_valid(h_tx_valid), .o_tx_ready(h_tx_ready), .i_tx_data(h_tx_data), .i_hold(h_hold),
        .o_rx_valid(h_rx_valid), .o_rx_data(h_rx_data), .o_frame_err(h_ferr),
        .o_parity_err(h_perr));
    hufc_assertions #(.P_READY_CYCLES(READY)) i_hufc_assertions (.i_ref_clk(i_ref_clk),
        .i_rst(i_rst), .host_link_transmit(link.host_link_transmit),
        .host_link_receive(link.host_link_receive),
        .host_link_request_to_send(link.host_link_request_to_send),
        .host_link_clear_to_send(link.host_link_clear_to_send));

    // 25 MHz reference
    initial begin
        i_ref_clk = 1'h0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    // collect bytes and sticky errors; cut a hang short
    always @(posedge i_ref_clk) begin
        if (h_rx_valid === 1'h1) hq.push_back(h_rx_data);
        if (d_rx_valid === 1'h1 && d_rx_ready === 1'h1) dq.push_back(d_rx_data);
        if (b_rx_valid === 1'h1) bq.push_back(b_rx_data);
        if (!i_rst && (d_ferr | d_perr | d_ovr | h_ferr | h_perr) !== 1'h0) err_seen <= 1'h1;
        if (b_ferr === 1'h1) b_ferr_seen <= 1'h1;
        if (b_perr === 1'h1) b_perr_seen <= 1'h1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // bounded wait for n bytes in q
    task automatic wait_q(ref logic [7:0] q[$], input int n);
        for (int k = 0; k < 3000 && q.size() < n; k++) @(posedge i_ref_clk);
    endtask

    // one byte into device (dev=1) or host, held until taken or lim edges pass
    task automatic push(input logic dev, input logic [7:0] b, input int lim, output logic ok);
        ok = 1'h0;
        if (dev) begin
            d_tx_valid <= 1'h1;
            d_tx_data <= b;
        end else begin
            h_tx_valid <= 1'h1;
            h_tx_data <= b;
        end
        for (int k = 0; k < lim && !ok; k++) begin
            @(posedge i_ref_clk);
            ok = ((dev ? d_tx_ready : h_tx_ready) === 1'h1);
        end
        d_tx_valid <= 1'h0;
        h_tx_valid <= 1'h0;
        @(posedge i_ref_clk);
    endtask

    // device line at eleven bit centres
    task automatic grab_tx(output logic [10:0] f);
        for (int k = 0; k < 200 && link.host_link_transmit !== 1'h0; k++) @(posedge i_ref_clk);
        repeat (4) @(posedge i_ref_clk);
        for (int k = 0; k < 11; k++) begin
            f[k] = link.host_link_transmit;
            repeat (8) @(posedge i_ref_clk);
        end
    endtask

    // rogue host on the second link: start, nine bits, stop
    task automatic send_raw(input logic [8:0] d, input logic stop);
        logic [10:0] f;
        f = {stop, d, 1'h0};
        b_ferr_seen <= 1'h0;
        b_perr_seen <= 1'h0;
        for (int b = 0; b < 11; b++) begin
            link_b.host_link_receive <= f[b];
            repeat (8) @(posedge i_ref_clk);
        end
        link_b.host_link_receive <= 1'h1;
        repeat (24) @(posedge i_ref_clk);
    endtask

    task automatic t_power_up();
        int k;
        check("rts after reset", 8'(link.host_link_request_to_send), 8'h01);
        for (k = 0; k < 60 && link.host_link_request_to_send !== 1'h0; k++) @(posedge i_ref_clk);
        check("rts low delay", 8'(k >= READY && k <= READY + 4), 8'h01);
        check("ready flag", 8'(d_ready), 8'h01);
    endtask

    // fill under cts, pause once, drain
    task automatic t_fill_drain();
        int n;
        n = 0;
        d_tx_valid <= 1'h1;
        d_tx_data <= 8'h00;
        repeat (40) begin
            @(posedge i_ref_clk);
            if (d_tx_ready === 1'h1) begin
                n++;
                d_tx_data <= 8'(n);
            end
        end
        d_tx_valid <= 1'h0;
        check("tx fifo depth", 8'(n), 8'(hufc_pkg::TX_FIFO_DEPTH));
        check("quiet under cts", 8'(link.host_link_transmit), 8'h01);
        h_hold <= 1'h0;
        for (n = 0; n < 60 && link.host_link_transmit !== 1'h0; n++) @(posedge i_ref_clk);
        check("cts low start", 8'(n < 50), 8'h01);
        wait_q(hq, 2);
        h_hold <= 1'h1;
        repeat (300) @(posedge i_ref_clk);
        check("cts stop", 8'(hq.size() <= 3), 8'h01);
        h_hold <= 1'h0;
        wait_q(hq, 16);
        for (n = 0; n < 16; n++) check("drained byte", hq[n], 8'(n));
        hq.delete();
    endtask

    // each parity mode both ways, device frame off the wire
    task automatic t_modes();
        logic ok;
        logic [7:0] b;
        logic [10:0] f;
        for (int m = 0; m < 3; m++) begin
            parity_en <= 1'(m != 0);
            parity_odd <= 1'(m == 2);
            b = 8'h3C ^ 8'(m);
            push(1'h0, 8'hA5 ^ 8'(m), 200, ok);
            push(1'h1, b, 200, ok);
            grab_tx(f);
            check("frame low", f[7:0], {b[6:0], 1'h0});
            check("frame high", 8'(f[10:8]), 8'({1'h1, (m == 0) | ((^b) ^ (m == 2)), b[7]}));
            wait_q(dq, 1);
            wait_q(hq, 1);
            check("to device", dq[0], 8'hA5 ^ 8'(m));
            check("to host", hq[0], b);
            dq.delete();
            hq.delete();
        end
        check("no errors", 8'(err_seen), 8'h00);
    endtask

    // device stops reading: host must stop in the slack
    task automatic t_throttle();
        int n;
        logic ok;
        d_rx_ready <= 1'h0;
        ok = 1'h1;
        for (n = 0; n < 40 && ok; n++) push(1'h0, 8'(n), 300, ok);
        n = n - 1;
        check("rts raised", 8'(link.host_link_request_to_send), 8'h01);
        check("host slack", 8'(n >= hufc_pkg::RX_THRESH
            && n <= hufc_pkg::RX_THRESH + hufc_pkg::FLOW_SLACK), 8'h01);
        d_rx_ready <= 1'h1;
        wait_q(dq, n);
        for (int k = 0; k < n; k++) check("held byte", dq[k], 8'(k));
        check("no loss", 8'(err_seen), 8'h00);
        check("rts released", 8'(link.host_link_request_to_send), 8'h00);
        push(1'h0, 8'h5A, 60, ok);
        check("host resumes", 8'(ok), 8'h01);
        wait_q(dq, n + 1);
        dq.delete();
    endtask

    // low stop, bad parity, good odd frame
    task automatic t_bad_frames();
        parity_en <= 1'h1;
        parity_odd <= 1'h0;
        send_raw({1'h0, 8'h96}, 1'h0);
        check("low stop flagged", 8'(b_ferr_seen), 8'h01);
        check("parity held", 8'(b_perr_seen), 8'h00);
        send_raw({1'h1, 8'h96}, 1'h1);
        check("parity flagged", 8'(b_perr_seen), 8'h01);
        check("stop good", 8'(b_ferr_seen), 8'h00);
        parity_odd <= 1'h1;
        bq.delete();
        send_raw({1'h1, 8'h96}, 1'h1);
        check("odd parity good", 8'(b_perr_seen | b_ferr_seen), 8'h00);
        check("lsb first data", bq[0], 8'h96);
    endtask

    initial begin
        i_rst = 1'h1;
        bit_cycles = 16'h0008;
        {parity_en, parity_odd, d_tx_valid, h_tx_valid} = 4'h0;
        {d_tx_data, h_tx_data} = 16'h0000;
        {d_rx_ready, h_hold} = 2'h3;
        link_b.host_link_receive = 1'h1;
        link_b.host_link_clear_to_send = 1'h1;
        {err_seen, b_ferr_seen, b_perr_seen} = 3'h0;
        failures = 0;
        n_tests = 0;
        cyc = 0;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'h0;
        @(posedge i_ref_clk);
        t_power_up();
        t_fill_drain();
        t_modes();
        t_throttle();
        t_bad_frames();
        close_out();
    end
endmodule
`default_nettype wire
